// >>> pkg/ees_pkg.sv
/*
 * shared constants, states and carriers of the serial memory read slave.
 * assumes a single core clock domain; the serial bus pins are sampled into it.
 */
package ees_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int HI_W = ADDR_W - DATA_W;
    localparam int MEM_DEPTH = 32768;
    localparam int LOG_DEPTH = 16;

    // device type code: arbitrary value, not tied to any product
    localparam logic [3:0] DEV_TYPE = 4'h6;
    localparam logic [2:0] DEV_SUB = 3'h0;
    localparam logic RW_READ = 1'b1;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 15'h7fff;

    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_DEV      = 8'h02,
        ST_DEV_ACK  = 8'h04,
        ST_ADDR     = 8'h08,
        ST_ADDR_ACK = 8'h10,
        ST_RD_LOAD  = 8'h20,
        ST_RD       = 8'h40,
        ST_RD_ACK   = 8'h80
    } ees_state_e;

    // one byte handed to the master, with the address it came from
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ees_rd_rec_s;

    // preload port of the memory array
    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ees_mem_wr_s;

    function automatic logic [ADDR_W-1:0] ees_addr_inc(input logic [ADDR_W-1:0] a);
        ees_addr_inc = a + ADDR_ONE;
    endfunction

endpackage

// >>> hdl/ees_read_slave.sv
// What this block does
// [R1] master nacks lone current-address byte, then STOP
// [R2] master's ack turns any read sequential
// [R3] on ack, next byte follows at once
// [R4] master ends sequential read: nack, STOP
// [R5] address counter plus one per byte out
// [R6] counter wraps past top to zero
// [R7] release data, sample ack in ninth bit
// [R8] no ack: stop driving, go stand-by
// [R9] current read outputs byte at counter
// [R10] dummy write loads counter, restart reads
// [R11] reads ignore the write protect level
// [R12] stand-by ignores bus until next START
/*
 * read side of a two-wire serial memory slave plus its read log fifo.
 * assumes scl and sda arrive asynchronously and are open drain on the board;
 * the master owns the serial clock, this block only stretches it low.
 */
`timescale 1ns/1ps

// ****************************************
// read log fifo
// ****************************************
module ees_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [0:DEPTH-1];
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
    wire logic push = in_valid & in_ready;
    wire logic pop = out_valid & out_ready;
    wire logic ptr_same = wr_ptr[PW-1:0] == rd_ptr[PW-1:0];

    assign in_ready = !(ptr_same && (wr_ptr[PW] != rd_ptr[PW]));
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[PW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (PW+1)'(push);
            rd_ptr <= rd_ptr + (PW+1)'(pop);
        end
    end
endmodule

// ****************************************
// serial read slave
// ****************************************
module ees_read_slave (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic write_protect_input,
    input wire ees_pkg::ees_mem_wr_s mem_wr,
    output ees_pkg::ees_rd_rec_s log_rec,
    output logic log_valid,
    input wire logic log_ready
);
    import ees_pkg::*;

    // ****************************************
    // pin sampling and bus events
    // ****************************************
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
        end
    end

    wire logic scl_rise = scl_s & ~scl_d;
    wire logic scl_fall = ~scl_s & scl_d;
    wire logic start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire logic stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // ****************************************
    // memory array
    // ****************************************
    logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

    always_ff @(posedge clk) begin
        if (mem_wr.en) begin
            mem[mem_wr.addr] <= mem_wr.data;
        end
    end

    // ****************************************
    // state and datapath
    // ****************************************
    ees_state_e state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [DATA_W-1:0] shift, next_shift;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [HI_W-1:0] addr_hi, next_addr_hi;
    logic ack_on, next_ack_on;
    logic byte_idx, next_byte_idx;
    logic rw, next_rw;
    logic pend, next_pend;
    logic next_sda_oe;
    logic fifo_ready;

    wire logic [DATA_W-1:0] mem_q = mem[addr];
    wire logic [DATA_W-1:0] rx_byte = {shift[DATA_W-2:0], sda_s};
    wire logic dev_hit = rx_byte[DATA_W-1:1] == {DEV_TYPE, DEV_SUB};
    wire logic last_bit = bit_cnt == BIT_LAST;
    wire logic load_go = (state == ST_RD_LOAD) && (scl_fall || pend);
    wire logic do_load = load_go && fifo_ready;
    wire ees_rd_rec_s push_rec = '{addr: addr, data: mem_q};

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_addr = addr;
        next_addr_hi = addr_hi;
        next_ack_on = ack_on;
        next_byte_idx = byte_idx;
        next_rw = rw;
        next_pend = pend;
        next_sda_oe = sda_oe;
        case (state)
            ST_IDLE: begin
                next_sda_oe = 1'b0; // R12
            end
            ST_DEV, ST_ADDR: begin
                if (scl_rise) begin
                    next_shift = rx_byte;
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (last_bit) begin
                        next_bit_cnt = BIT_FIRST;
                        next_rw = sda_s;
                        if (state == ST_ADDR) begin
                            next_state = ST_ADDR_ACK;
                        end else begin
                            next_state = dev_hit ? ST_DEV_ACK : ST_IDLE;
                        end
                    end
                end
            end
            ST_DEV_ACK: begin
                if (scl_fall) begin
                    next_ack_on = !ack_on;
                    next_sda_oe = !ack_on;
                    if (ack_on) begin
                        if (rw == RW_READ) begin
                            next_state = ST_RD_LOAD; // R9
                            next_pend = 1'b1;
                        end else begin
                            next_state = ST_ADDR;
                            next_byte_idx = 1'b0;
                        end
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    next_ack_on = !ack_on;
                    next_sda_oe = !ack_on;
                    if (ack_on) begin
                        if (!byte_idx) begin
                            next_addr_hi = shift[HI_W-1:0];
                            next_byte_idx = 1'b1;
                            next_state = ST_ADDR;
                        end else begin
                            next_addr = {addr_hi, shift}; // R10
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            ST_RD_LOAD: begin
                // loads regardless of the write protect level
                if (do_load) begin // R11
                    next_shift = {mem_q[DATA_W-2:0], 1'b0};
                    next_sda_oe = ~mem_q[DATA_W-1];
                    next_addr = ees_addr_inc(addr); // R5 R6
                    next_bit_cnt = BIT_FIRST;
                    next_pend = 1'b0;
                    next_state = ST_RD;
                end else if (load_go) begin
                    next_pend = 1'b1;
                end
            end
            ST_RD: begin
                if (scl_fall) begin
                    if (last_bit) begin
                        next_sda_oe = 1'b0; // R7
                        next_state = ST_RD_ACK;
                    end else begin
                        next_sda_oe = ~shift[DATA_W-1];
                        next_shift = {shift[DATA_W-2:0], 1'b0};
                        next_bit_cnt = bit_cnt + 3'h1;
                    end
                end
            end
            ST_RD_ACK: begin
                if (scl_rise) begin
                    next_state = sda_s ? ST_IDLE : ST_RD_LOAD; // R3 R8 R2
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (start_det) begin
            next_state = ST_DEV; // R12
            next_bit_cnt = BIT_FIRST;
            next_sda_oe = 1'b0;
            next_ack_on = 1'b0;
            next_pend = 1'b0;
        end else if (stop_det) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
            next_ack_on = 1'b0;
            next_pend = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bit_cnt <= BIT_FIRST;
            shift <= '0;
            addr <= ADDR_ZERO;
            addr_hi <= '0;
            ack_on <= 1'b0;
            byte_idx <= 1'b0;
            rw <= 1'b0;
            pend <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            addr <= next_addr;
            addr_hi <= next_addr_hi;
            ack_on <= next_ack_on;
            byte_idx <= next_byte_idx;
            rw <= next_rw;
            pend <= next_pend;
            sda_oe <= next_sda_oe;
        end
    end

    // open drain: only ever pull low; scl held low while a byte load is pending, as on a full log
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign scl_oe = pend;

    ees_fifo #(
        .W($bits(ees_rd_rec_s)),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(load_go),
        .in_ready(fifo_ready),
        .in_data(push_rec),
        .out_valid(log_valid),
        .out_ready(log_ready),
        .out_data(log_rec)
    );

    // ****************************************
    // checks
    // ****************************************
    // scl falls seen while one byte is shifted out
    logic [3:0] fall_cnt;
    always_ff @(posedge clk) begin
        if (!rst_b || do_load) begin
            fall_cnt <= '0;
        end else if (state == ST_RD && scl_fall) begin
            fall_cnt <= fall_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_addr_step: assert property (do_load && addr != ADDR_TOP |=> addr == $past(addr) + ADDR_ONE) // R5
        else $error("address counter did not step by one");
    chk_addr_wrap: assert property (do_load && addr == ADDR_TOP |=> addr == ADDR_ZERO) // R6
        else $error("address counter did not wrap to zero");
    chk_ack_release: assert property (state == ST_RD_ACK |-> !sda_oe) // R7
        else $error("data line driven during acknowledge slot");
    chk_nack_idle: assert property (state == ST_RD_ACK && scl_rise && sda_s && !start_det && !stop_det
        |=> state == ST_IDLE ##1 !sda_oe) // R8
        else $error("no stand-by after missing acknowledge");
    chk_ack_next: assert property (state == ST_RD_ACK && scl_rise && !sda_s && !start_det && !stop_det
        |=> state == ST_RD_LOAD) // R3
        else $error("acknowledged read did not fetch next byte");
    chk_first_bit: assert property (do_load && !start_det && !stop_det
        |=> sda_oe == !$past(mem_q[DATA_W-1]) && state == ST_RD) // R9
        else $error("first data bit does not match stored byte");
    chk_idle_quiet: assert property (state == ST_IDLE && !start_det |=> state == ST_IDLE && addr == $past(addr)) // R12
        else $error("stand-by reacted to bus activity");
    chk_addr_load: assert property (state == ST_ADDR_ACK && scl_fall && ack_on && byte_idx && !start_det && !stop_det
        |=> addr == {$past(addr_hi), $past(shift)}) // R10
        else $error("dummy write did not load address counter");
    chk_byte_len: assert property (state == ST_RD ##1 state == ST_RD_ACK |-> fall_cnt == 4'(DATA_W)) // R7
        else $error("read byte not eight clock periods long");

    cov_seq_read: cover property (state == ST_RD_ACK && scl_rise && !sda_s ##[1:1000] do_load);
    cov_wrap: cover property (do_load && addr == ADDR_TOP);
    cov_nack_end: cover property (state == ST_RD_ACK && scl_rise && sda_s);
    cov_stretch: cover property (pend && !fifo_ready);
endmodule

// >>> testbench/ees_bus_master.sv
/*
 * bus master model for the serial memory read slave.
 * assumes open drain wires with pull-ups resolved in the bench.
 */
`timescale 1ns/1ps

module ees_bus_master (
    input wire logic clk,
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_low,
    output logic sda_low
);
    // ****************************************
    // bit level
    // ****************************************
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic bit_x(input logic b, output logic r);
        int n;
        sda_low = !b;
        wt(2);
        scl_low = 1'b0;
        n = 0;
        // the slave may stretch the clock low
        while (!scl_w && n < 400) begin
            wt(1);
            n++;
        end
        wt(2);
        r = sda_w;
        wt(1);
        scl_low = 1'b1;
        wt(3);
    endtask

    // ****************************************
    // framing and bytes
    // ****************************************
    task automatic start();
        sda_low = 1'b0;
        wt(2);
        scl_low = 1'b0;
        wt(4);
        sda_low = 1'b1;
        wt(4);
        scl_low = 1'b1;
        wt(4);
    endtask

    task automatic stop();
        sda_low = 1'b1;
        wt(2);
        scl_low = 1'b0;
        wt(4);
        sda_low = 1'b0;
        wt(6);
    endtask

    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, v[i]);
        end
        // ack keeps the read going, nack ends it
        bit_x(last, r);
    endtask
endmodule

// >>> testbench/test_ees_read_slave.sv
/*
 * self-checking bench of the serial memory read slave.
 * assumes the bus master model and pull-up resolution of both wires.
 */
`timescale 1ns/1ps

module test_ees_read_slave;
    import ees_pkg::*;
    logic clk, rst_b, wp, log_ready, log_valid, seen_oe;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low, scl_w, sda_w;
    ees_mem_wr_s mem_wr;
    ees_rd_rec_s log_rec;
    ees_rd_rec_s q[$];
    int mismatches;
    int comparisons;

    assign scl_w = !(scl_low || (scl_oe && !scl_o));
    assign sda_w = !(sda_low || (sda_oe && !sda_o));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (rst_b && log_valid && log_ready) q.push_back(log_rec);
        if (sda_oe) seen_oe = 1'b1;
    end

    ees_read_slave i_dut (.clk(clk), .rst_b(rst_b), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .write_protect_input(wp), .mem_wr(mem_wr),
        .log_rec(log_rec), .log_valid(log_valid), .log_ready(log_ready));
    ees_bus_master i_mst (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
        pat = a[7:0] ^ {a[14:8], 1'b1} ^ 8'h3c;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic preload(input logic [ADDR_W-1:0] a, input int n);
        for (int k = 0; k < n; k++) begin
            mem_wr = '{en: 1'b1, addr: a, data: pat(a)};
            @(posedge clk);
            #1;
            a = a + ADDR_ONE;
        end
        mem_wr.en = 1'b0;
    endtask

    task automatic sel(input logic rw);
        logic k;
        i_mst.start();
        i_mst.wr_byte({DEV_TYPE, DEV_SUB, rw}, k);
        chk(32'(k), 32'h1);
    endtask

    task automatic set_addr(input logic [ADDR_W-1:0] a);
        logic k;
        sel(1'b0);
        i_mst.wr_byte({1'b0, a[14:8]}, k);
        chk(32'(k), 32'h1);
        i_mst.wr_byte(a[7:0], k);
        chk(32'(k), 32'h1);
        sel(RW_READ);
    endtask

    task automatic rd_n(input logic [ADDR_W-1:0] a, input int n, input logic nack_end);
        logic [7:0] v;
        for (int k = 0; k < n; k++) begin
            i_mst.rd_byte(nack_end && k == n - 1, v);
            chk(32'(v), 32'(pat(a)));
            a = a + ADDR_ONE;
        end
    endtask

    task automatic chk_log(input logic [ADDR_W-1:0] a, input int n);
        chk(32'(q.size()), 32'(n));
        for (int k = 0; k < q.size(); k++) begin
            chk(32'(q[k]), 32'({a, pat(a)}));
            a = a + ADDR_ONE;
        end
        q.delete();
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_seq_wrap();
        wp = 1'b1;
        set_addr(15'h7ffe);
        rd_n(15'h7ffe, 4, 1'b1);
        i_mst.stop();
        chk_log(15'h7ffe, 4);
        $display("test seq_wrap done");
    endtask

    task automatic t_standby();
        logic b;
        wp = 1'b0;
        seen_oe = 1'b0;
        i_mst.scl_low = 1'b1;
        i_mst.wt(4);
        for (int k = 0; k < 9; k++) begin
            i_mst.bit_x(1'b0, b);
        end
        chk(32'(seen_oe), 32'h0);
        i_mst.start();
        i_mst.wr_byte({~DEV_TYPE, DEV_SUB, RW_READ}, b);
        chk(32'(b), 32'h0);
        sel(RW_READ);
        rd_n(15'h0002, 2, 1'b1);
        i_mst.stop();
        chk_log(15'h0002, 2);
        $display("test standby done");
    endtask

    task automatic t_fifo_full();
        logic [7:0] v;
        log_ready = 1'b0;
        set_addr(15'h0010);
        rd_n(15'h0010, 16, 1'b0);
        chk(32'(log_valid), 32'h1);
        fork
            i_mst.rd_byte(1'b1, v);
            begin
                repeat (20) @(posedge clk);
                #1;
                chk(32'(scl_oe), 32'h1);
                log_ready = 1'b1;
            end
        join
        chk(32'(v), 32'(pat(15'h0020)));
        i_mst.stop();
        chk_log(15'h0010, 17);
        chk(32'(log_valid), 32'h0);
        $display("test fifo_full done");
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        mismatches++;
        print_verdict();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        wp = 1'b0;
        log_ready = 1'b1;
        seen_oe = 1'b0;
        mem_wr = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        preload(15'h7ffe, 6);
        preload(15'h0010, 17);
        t_seq_wrap();
        t_standby();
        t_fifo_full();
        print_verdict();
    end
endmodule
